/* File: core/oag_pkg.sv */
// Constants shared by the operand address generator files.
// Assumes a 16-bit datapath with eight general registers.
package oag_pkg;

	// Addressing modes carried in the 3-bit mode field
	typedef enum logic [2:0] {
		OAG_MODE_REG = 3'h0,
		OAG_MODE_DEFER = 3'h1,
		OAG_MODE_AUTOINC = 3'h2,
		OAG_MODE_AUTOINC_DEF = 3'h3,
		OAG_MODE_AUTODEC = 3'h4,
		OAG_MODE_AUTODEC_DEF = 3'h5,
		OAG_MODE_INDEX = 3'h6,
		OAG_MODE_INDEX_DEF = 3'h7
	} oag_mode_t;

	localparam int OAG_DW = 16;
	localparam int OAG_NREG = 8;
	localparam logic [2:0] OAG_STACK_POINTER_REG = 3'h6;
	localparam logic [2:0] OAG_INSTRUCTION_POINTER_REG = 3'h7;
	localparam logic [15:0] OAG_WORD_STEP = 16'h0002;
	localparam logic [15:0] OAG_BYTE_STEP = 16'h0001;
	localparam logic [15:0] OAG_REG_RST = 16'h0000;
	localparam logic [15:0] OAG_EA_RST = 16'h0000;

endpackage

/* File: core/oag_step.sv */
// Register step unit: adds or subtracts the operand step from a register value.
// Assumes the caller selects direction and whether the step is forced to a word.
`timescale 1ns/1ps
`default_nettype none
module oag_step
	import oag_pkg::*;
(
	input wire logic [15:0] val,
	input wire logic [2:0] sel,
	input wire logic byte_op,
	input wire logic force_word,
	input wire logic dec,
	output logic [15:0] result
);

	// Pointer registers always move a whole word so they stay aligned
	wire logic use_byte = byte_op && !force_word && (sel < OAG_STACK_POINTER_REG);
	wire logic [15:0] step = use_byte ? OAG_BYTE_STEP : OAG_WORD_STEP;
	assign result = dec ? (val - step) : (val + step);

endmodule
`default_nettype wire

/* File: core/oag_top.sv */
// Operand effective-address generator with its own eight-entry register file.
// Assumes a single-word memory read port that answers with a one-cycle ack.
//
// Behaviour
// - Mode 0 returns the selected register as the operand with no memory access.
// - Mode 1 uses the register as the operand address and leaves it unchanged.
// - Mode 2 uses the register as address, then adds 2 for words or 1 for bytes.
// - Stack pointer and instruction pointer always step by 2, even for bytes.
// - Mode 3 reads a pointer word at the register address, then adds 2 to the register.
// - Mode 4 subtracts 2 for words or 1 for bytes first and uses the result as address.
// - Mode 5 subtracts 2 first and reads the operand address from the resulting location.
// - Mode 6 fetches the next word and adds the register to it to form the address.
// - Mode 7 forms the mode 6 sum and reads the operand address stored there.
// - Every implicit fetch through the instruction pointer advances it by 2: at the ack, or for mode 3 when the read is issued.
// - Mode 2 on the instruction pointer fetches the next word as an immediate operand.
// - Mode 3 on the instruction pointer takes the next word as an absolute address.
// - Mode 6 on the instruction pointer adds the offset to the advanced pointer.
// - Mode 7 on the instruction pointer adds the offset to the advanced pointer, then defers.
`timescale 1ns/1ps
`default_nettype none
module oag_top
	import oag_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire oag_pkg::oag_mode_t mode,
	input wire logic [2:0] sel,
	input wire logic byte_op,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire logic reg_ld_en,
	input wire logic [2:0] reg_ld_sel,
	input wire logic [15:0] reg_ld_data,
	input wire logic [2:0] reg_rd_sel,
	output logic busy,
	output logic done,
	output logic [15:0] ea,
	output logic [15:0] operand,
	output logic operand_in_reg,
	output logic mem_req,
	output logic [15:0] mem_addr,
	output logic [15:0] reg_rd_data
);
	import oag_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_FETCH_IDX, S_ADD, S_PTR, S_IMM} oag_state_t;

	oag_state_t state_r, state_nxt;
	oag_mode_t mode_r;
	logic [2:0] sel_r;
	logic byte_r;
	logic [15:0] rf_r [OAG_NREG];
	logic [15:0] idx_r, idx_nxt;
	logic [15:0] ea_r, ea_nxt, opnd_r, opnd_nxt, addr_r, addr_nxt, rd_r;
	logic in_reg_r, in_reg_nxt, req_r, req_nxt, done_r, done_nxt, busy_r;
	logic rf_we;
	logic [2:0] rf_wsel;
	logic [15:0] rf_wdata;

	// Decode: the request fields are live in idle, latched copies afterwards
	wire logic idle = (state_r == S_IDLE);
	wire oag_mode_t cur_mode = idle ? mode : mode_r;
	wire logic [2:0] cur_sel = idle ? sel : sel_r;
	wire logic cur_byte = idle ? byte_op : byte_r;
	wire logic [15:0] cur_reg = rf_r[cur_sel];
	wire logic [15:0] ip_val = rf_r[OAG_INSTRUCTION_POINTER_REG];
	wire logic sel_is_ip = (cur_sel == OAG_INSTRUCTION_POINTER_REG);
	wire logic [15:0] idx_sum = idx_r + cur_reg;
	wire logic load_ok = reg_ld_en && idle && !start;
	logic [15:0] inc_val, dec_val, ip_next;

	// Mode 3 and 5 always step by a word since the register points at addresses
	oag_step u_inc (
		.val(cur_reg),
		.sel(cur_sel),
		.byte_op(cur_byte),
		.force_word(cur_mode != OAG_MODE_AUTOINC),
		.dec(1'b0),
		.result(inc_val)
	);
	oag_step u_dec (
		.val(cur_reg),
		.sel(cur_sel),
		.byte_op(cur_byte),
		.force_word(cur_mode != OAG_MODE_AUTODEC),
		.dec(1'b1),
		.result(dec_val)
	);
	oag_step u_ip (
		.val(ip_val),
		.sel(OAG_INSTRUCTION_POINTER_REG),
		.byte_op(1'b0),
		.force_word(1'b1),
		.dec(1'b0),
		.result(ip_next)
	);

	// Sequencer: one memory read outstanding at a time, held until acked
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		ea_nxt = ea_r;
		opnd_nxt = opnd_r;
		in_reg_nxt = in_reg_r;
		req_nxt = req_r;
		addr_nxt = addr_r;
		done_nxt = 1'b0;
		rf_we = load_ok;
		rf_wsel = reg_ld_sel;
		rf_wdata = reg_ld_data;
		case (state_r)
			S_IDLE: begin
				if (start) begin
					in_reg_nxt = 1'b0;
					case (cur_mode)
						OAG_MODE_REG: begin
							opnd_nxt = cur_reg;
							in_reg_nxt = 1'b1;
							ea_nxt = OAG_EA_RST;
							done_nxt = 1'b1;
						end
						OAG_MODE_DEFER: begin
							ea_nxt = cur_reg;
							done_nxt = 1'b1;
						end
						OAG_MODE_AUTOINC: begin
							if (sel_is_ip) begin
								req_nxt = 1'b1;
								addr_nxt = ip_val;
								state_nxt = S_IMM;
							end else begin
								ea_nxt = cur_reg;
								rf_we = 1'b1;
								rf_wsel = cur_sel;
								rf_wdata = inc_val;
								done_nxt = 1'b1;
							end
						end
						OAG_MODE_AUTOINC_DEF: begin
							req_nxt = 1'b1;
							addr_nxt = cur_reg;
							rf_we = 1'b1;
							rf_wsel = cur_sel;
							rf_wdata = inc_val;
							state_nxt = S_PTR;
						end
						OAG_MODE_AUTODEC: begin
							ea_nxt = dec_val;
							rf_we = 1'b1;
							rf_wsel = cur_sel;
							rf_wdata = dec_val;
							done_nxt = 1'b1;
						end
						OAG_MODE_AUTODEC_DEF: begin
							req_nxt = 1'b1;
							addr_nxt = dec_val;
							rf_we = 1'b1;
							rf_wsel = cur_sel;
							rf_wdata = dec_val;
							state_nxt = S_PTR;
						end
						default: begin
							req_nxt = 1'b1;
							addr_nxt = ip_val;
							state_nxt = S_FETCH_IDX;
						end
					endcase
				end
			end
			S_FETCH_IDX: begin
				if (mem_ack) begin
					req_nxt = 1'b0;
					idx_nxt = mem_rdata;
					rf_we = 1'b1;
					rf_wsel = OAG_INSTRUCTION_POINTER_REG;
					rf_wdata = ip_next;
					state_nxt = S_ADD;
				end
			end
			S_ADD: begin
				// Pointer was advanced last cycle, so a relative base is instruction + 4
				if (mode_r == OAG_MODE_INDEX) begin
					ea_nxt = idx_sum;
					done_nxt = 1'b1;
					state_nxt = S_IDLE;
				end else begin
					req_nxt = 1'b1;
					addr_nxt = idx_sum;
					state_nxt = S_PTR;
				end
			end
			S_PTR: begin
				if (mem_ack) begin
					req_nxt = 1'b0;
					ea_nxt = mem_rdata;
					done_nxt = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			S_IMM: begin
				if (mem_ack) begin
					req_nxt = 1'b0;
					opnd_nxt = mem_rdata;
					ea_nxt = addr_r;
					rf_we = 1'b1;
					rf_wsel = OAG_INSTRUCTION_POINTER_REG;
					rf_wdata = ip_next;
					done_nxt = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_IDLE;
				req_nxt = 1'b0;
			end
		endcase
	end

	// Control and output flops
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r <= S_IDLE;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			req_r <= 1'b0;
			in_reg_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_r <= (state_nxt != S_IDLE);
			done_r <= done_nxt;
			req_r <= req_nxt;
			in_reg_r <= in_reg_nxt;
		end
	end

	// Datapath flops and request latch
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_r <= OAG_MODE_REG;
			sel_r <= 3'h0;
			byte_r <= 1'b0;
			idx_r <= OAG_REG_RST;
			ea_r <= OAG_EA_RST;
			opnd_r <= OAG_REG_RST;
			addr_r <= OAG_REG_RST;
			rd_r <= OAG_REG_RST;
		end else begin
			mode_r <= cur_mode;
			sel_r <= cur_sel;
			byte_r <= cur_byte;
			idx_r <= idx_nxt;
			ea_r <= ea_nxt;
			opnd_r <= opnd_nxt;
			addr_r <= addr_nxt;
			rd_r <= rf_r[reg_rd_sel];
		end
	end

	// General register file, one write port shared by sequencer and loader
	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < OAG_NREG; i++) begin
				rf_r[i] <= OAG_REG_RST;
			end
		end else if (rf_we) begin
			rf_r[rf_wsel] <= rf_wdata;
		end
	end

	assign busy = busy_r;
	assign done = done_r;
	assign ea = ea_r;
	assign operand = opnd_r;
	assign operand_in_reg = in_reg_r;
	assign mem_req = req_r;
	assign mem_addr = addr_r;
	assign reg_rd_data = rd_r;

endmodule
`default_nettype wire

/* File: tb/oag_mem.sv */
// Behavioural memory answering single-word reads.
// Assumes mem_req is held until acknowledged; lat adds wait cycles.
`timescale 1ns/1ps
`default_nettype none
module oag_mem (
	input wire logic clk,
	input wire logic rstn,
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic [3:0] lat,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [3:0] wait_r;
	// Data toggles off the ack cycle so stale data never passes as valid
	always_ff @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!rstn) begin
			wait_r <= '0;
			mem_rdata <= '0;
		end else if (mem_req && !mem_ack) begin
			if (wait_r == lat) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_addr ^ 16'ha5a5;
				wait_r <= '0;
			end else
				wait_r <= wait_r + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/oag_monitor.sv */
// Port checks for the operand address generator.
// Assumes one clock domain and the synchronous active-low reset of the top.
`timescale 1ns/1ps
`default_nettype none
module oag_monitor
	import oag_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire oag_pkg::oag_mode_t mode,
	input wire logic [2:0] sel,
	input wire logic busy,
	input wire logic done,
	input wire logic operand_in_reg,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [15:0] mem_addr
);
	import oag_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Taken requests, split by whether they need the memory port
	wire taken = start && !busy;
	wire no_mem = mode inside {OAG_MODE_REG, OAG_MODE_DEFER, OAG_MODE_AUTODEC}
		|| (mode == OAG_MODE_AUTOINC && sel != OAG_INSTRUCTION_POINTER_REG);
	sequence s_fast; taken && no_mem; endsequence
	sequence s_slow; taken && !no_mem; endsequence
	sequence s_ack; mem_req && mem_ack; endsequence
	property p_fast; s_fast |=> done && !mem_req; endproperty
	property p_reg; taken && mode == OAG_MODE_REG |=> operand_in_reg; endproperty
	property p_slow; s_slow |=> mem_req && busy && !done; endproperty
	property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
	property p_drop; s_ack |=> !mem_req; endproperty
	property p_busy; mem_req |-> busy && !done; endproperty
	property p_late; done && $past(busy) |-> $past(mem_ack) || $past(mem_ack, 2); endproperty
	property p_fall; $fell(busy) |-> done; endproperty
	a_fast: assert property (p_fast) else $error("no done after fast mode");
	a_reg: assert property (p_reg) else $error("register operand flag low");
	a_slow: assert property (p_slow) else $error("no read for memory mode");
	a_hold: assert property (p_hold) else $error("read dropped early");
	a_drop: assert property (p_drop) else $error("read held after ack");
	a_busy: assert property (p_busy) else $error("read while idle");
	a_late: assert property (p_late) else $error("done not after a read");
	a_fall: assert property (p_fall) else $error("busy fell without done");
endmodule
bind oag_top oag_monitor mon (.clk, .rstn, .start, .mode, .sel, .busy, .done, .operand_in_reg,
	.mem_req, .mem_ack, .mem_addr);
`default_nettype wire

/* File: tb/tb_word_operand_address_gen.sv */
// Self-checking bench for the operand address generator.
// Assumes the memory model returns addr ^ 16'ha5a5 for every read.
`timescale 1ns/1ps
`default_nettype none
module tb_word_operand_address_gen;
	import oag_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, start = 1'b0, byte_op = 1'b0, reg_ld_en = 1'b0;
	oag_mode_t mode = OAG_MODE_REG;
	logic [2:0] sel = '0, reg_ld_sel = '0, reg_rd_sel = '0;
	logic [15:0] reg_ld_data = '0, ea, operand, mem_addr, mem_rdata, reg_rd_data;
	logic busy, done, operand_in_reg, mem_req, mem_ack;
	logic [3:0] lat = '0;
	int failures = 0, cmp_count = 0, cyc = 0;
	// Rows: select, mode and byte flag, start value, expected address, register after
	logic [55:0] tab [0:17] = '{56'h20_1000_0000_1000, 56'h22_1000_1000_1000,
		56'h24_1000_1000_1002, 56'h25_1000_1000_1001, 56'h26_1000_b5a5_1002,
		56'h28_1000_0ffe_0ffe, 56'h29_1000_0fff_0fff, 56'h2a_1000_aa5b_0ffe,
		56'h2c_1000_b7a5_1000, 56'h2e_1000_1200_1000, 56'h65_2000_2000_2002,
		56'h69_2000_1ffe_1ffe, 56'h75_0102_0102_0104, 56'h76_0102_a4a7_0104,
		56'h7c_0102_a5ab_0104, 56'h7e_0102_000e_0104,
		56'h27_1000_b5a5_1002, 56'h2b_1000_aa5b_0ffe};
	// The last two rows are byte requests in modes 3 and 5, which must still step by a word
	oag_top uut (.clk, .rstn, .start, .mode, .sel, .byte_op, .mem_ack, .mem_rdata, .reg_ld_en,
		.reg_ld_sel, .reg_ld_data, .reg_rd_sel, .busy, .done, .ea, .operand, .operand_in_reg,
		.mem_req, .mem_addr, .reg_rd_data);
	oag_mem mem (.clk, .rstn, .mem_req, .mem_addr, .lat, .mem_ack, .mem_rdata);
	initial forever #2 clk = ~clk;
	// Hang guard well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			end_of_test;
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task load(input logic [2:0] s, input logic [15:0] d);
		@(negedge clk);
		reg_ld_en = 1'b1;
		reg_ld_sel = s;
		reg_ld_data = d;
		@(negedge clk);
		reg_ld_en = 1'b0;
	endtask
	task go(input logic [3:0] mb, input logic [2:0] s);
		@(negedge clk);
		mode = oag_mode_t'(mb[3:1]);
		byte_op = mb[0];
		sel = s;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
	endtask
	// Waits for done with a bound, then checks address and register, and the operand for mode 0 and for mode 2 on the instruction pointer
	task fin(input logic [2:0] s, input logic [15:0] e_ea, input logic [15:0] e_reg);
		int n;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		// A request that never finishes counts as a mismatch, not only a wrong address
		chk({15'h0000, done}, 16'h0001);
		chk(ea, e_ea);
		if (mode == OAG_MODE_REG) chk(operand, e_reg);
		if (mode == OAG_MODE_AUTOINC && s == 3'h7) chk(operand, e_ea ^ 16'ha5a5);
		reg_rd_sel = s;
		repeat (2) @(negedge clk);
		chk(reg_rd_data, e_reg);
	endtask
	task t_modes;
		for (int i = 0; i < 18; i++) begin
			lat = 4'(i % 3);
			load(3'h7, 16'h0200);
			load(tab[i][54:52], tab[i][47:32]);
			go(tab[i][51:48], tab[i][54:52]);
			fin(tab[i][54:52], tab[i][31:16], tab[i][15:0]);
		end
		$display("test modes finished");
	endtask
	// A second start and a register load while busy must both be ignored
	task t_busy;
		lat = 4'h4;
		load(3'h7, 16'h0200);
		load(3'h2, 16'h1000);
		go(4'hc, 3'h2);
		@(negedge clk);
		start = 1'b1;
		mode = OAG_MODE_REG;
		reg_ld_en = 1'b1;
		reg_ld_data = 16'h5555;
		reg_ld_sel = 3'h2;
		@(negedge clk);
		start = 1'b0;
		mode = OAG_MODE_INDEX;
		reg_ld_en = 1'b0;
		fin(3'h2, 16'hb7a5, 16'h1000);
		$display("test busy finished");
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		t_modes;
		t_busy;
		end_of_test;
	end
endmodule
`default_nettype wire
